/* logic/cmcs_pkg.sv */
// Shared constants and types of the machine-cycle sequencer
package cmcs_pkg;
	localparam int DW = 16;
	localparam int CW = 8;
	localparam logic [7:0] ALU_CLKS = 8'h02;
	localparam logic [7:0] BIT_CLKS = 8'h02;
	localparam logic [7:0] WIDE_BASE_CLKS = 8'h02;
	localparam logic [7:0] NARROW_BASE_CLKS = 8'h04;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [15:0] SD_RESET = 16'h0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] INC_BYTE = 16'h0001;
	localparam logic [15:0] INC_WORD = 16'h0002;
	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [2:0] LEN_REG = 3'h1;
	localparam logic [2:0] LEN_IND = 3'h3;
	localparam logic [2:0] LEN_AUTO_B = 3'h4;
	localparam logic [2:0] LEN_LONG = 3'h5;

	typedef enum logic [1:0] {BK_RD = 2'h0, BK_WR = 2'h1, BK_BIN = 2'h2, BK_BOUT = 2'h3} cmcs_bkind_t;
	typedef enum logic [2:0] {OP_END = 3'h0, OP_ALU = 3'h1, OP_RD = 3'h2, OP_WR = 3'h3,
		OP_BIN = 3'h4, OP_BOUT = 3'h5} cmcs_op_t;
	typedef enum logic [2:0] {A_WSA = 3'h0, A_WSC = 3'h1, A_PC2 = 3'h2, A_SYM = 3'h3,
		A_SYMX = 3'h4, A_EXT = 3'h5} cmcs_asrc_t;
	typedef enum logic [2:0] {D_KEEP = 3'h0, D_ZERO = 3'h1, D_WSC = 3'h2, D_INC = 3'h3,
		D_EXT = 3'h4} cmcs_dsrc_t;
	typedef struct packed {
		cmcs_op_t   op;
		cmcs_asrc_t asrc;
		cmcs_dsrc_t dsrc;
	} cmcs_step_t;
	typedef enum logic [2:0] {M_REG = 3'h0, M_IND = 3'h1, M_AUTO = 3'h2, M_SYM = 3'h3,
		M_IDX = 3'h4} cmcs_mode_t;
	typedef enum logic [2:0] {C_ALU_KEEP = 3'h0, C_ALU_LOAD = 3'h1, C_RD = 3'h2, C_WR = 3'h3,
		C_BIN = 3'h4, C_BOUT = 3'h5} cmcs_cmd_t;
	typedef enum logic [3:0] {S_IDLE = 4'h1, S_ALU0 = 4'h2, S_ALU1 = 4'h4, S_BUS = 4'h8} cmcs_state_t;
	typedef enum logic [2:0] {E_IDLE = 3'h1, E_T1 = 3'h2, E_T2 = 3'h4} cmcs_estate_t;
endpackage : cmcs_pkg

/* logic/cmcs_bus_if.sv */
// Link between the step sequencer and the bus cycle engine
`timescale 1ns/100ps
interface cmcs_bus_if;
	import cmcs_pkg::*;
	logic        req;
	cmcs_bkind_t kind;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic        wbit;
	logic        narrow;
	logic [15:0] sd;
	logic        done;
	logic [15:0] rdata;
	logic        rbit;
	modport seq (output req, kind, addr, wdata, wbit, narrow, sd, input done, rdata, rbit);
	modport eng (input req, kind, addr, wdata, wbit, narrow, sd, output done, rdata, rbit);
endinterface : cmcs_bus_if

/* logic/cmcs_bus_engine.sv */
// Memory and serial bit cycle engine
`timescale 1ns/100ps
module cmcs_bus_engine
	import cmcs_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	cmcs_bus_if.eng    b,
	input  wire logic  wait_sync,
	input  wire logic  serial_in_sync,
	input  wire logic [15:0] din,
	output logic [15:0] address_bus_value,
	output logic [15:0] data_bus_value,
	output logic        data_bus_oe,
	output logic        mem_enable,
	output logic        mem_we_n,
	output logic        byte_select_address_bit,
	output logic        serial_bit_out,
	output logic        serial_bit_strobe
);
	cmcs_estate_t st;
	cmcs_bkind_t  kind;
	logic         narrow_q;
	logic         byte_hi;
	logic [15:0]  wdata_q;
	logic [7:0]   rdata_hi;
	logic [7:0]   cyc_cnt;
	logic [7:0]   stall_cnt;
	logic         is_mem;
	logic         stall;
	logic         next_byte;
	logic         last;
	logic         bin_tail;
	logic         rbit_q;

	// ****************************************
	// Cycle progress
	// ****************************************
	always_comb begin
		is_mem = (kind == BK_RD) || (kind == BK_WR);
		stall = (st == E_T2) && is_mem && wait_sync;
		next_byte = (st == E_T2) && is_mem && !wait_sync && narrow_q && !byte_hi;
		last = (st == E_T2) && !stall && !next_byte;
	end

	assign b.done = last;
	assign b.rdata = narrow_q ? {rdata_hi, din[7:0]} : din;
	assign b.rbit = rbit_q;

	// Synchroniser delay: the pin taken at the start of the second clock lands one clock after the cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bin_tail <= 1'b0;
			rbit_q <= 1'b0;
		end else begin
			bin_tail <= last && (kind == BK_BIN);
			if (bin_tail) begin
				rbit_q <= serial_in_sync;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= E_IDLE;
		end else if (b.req) begin
			st <= E_T1;
		end else begin
			case (st)
				E_T1: st <= E_T2;
				E_T2: st <= next_byte ? E_T1 : (stall ? E_T2 : E_IDLE);
				default: st <= E_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			kind <= BK_RD;
			narrow_q <= 1'b0;
			byte_hi <= 1'b0;
			wdata_q <= ZERO_WORD;
			rdata_hi <= 8'h00;
		end else if (b.req) begin
			kind <= b.kind;
			narrow_q <= b.narrow;
			byte_hi <= 1'b0;
			wdata_q <= b.wdata;
		end else if (next_byte) begin
			byte_hi <= 1'b1;
			rdata_hi <= din[7:0];
		end
	end

	// ****************************************
	// Bus pins
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			address_bus_value <= ADDR_RESET;
			byte_select_address_bit <= 1'b0;
		end else if (b.req) begin
			address_bus_value <= b.addr;
			byte_select_address_bit <= b.addr[0];
			if (b.narrow && (b.kind == BK_RD || b.kind == BK_WR)) begin
				address_bus_value[0] <= 1'b0;
				byte_select_address_bit <= 1'b0;
			end
		end else if (next_byte) begin
			address_bus_value[0] <= 1'b1;
			byte_select_address_bit <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_bus_value <= SD_RESET;
			data_bus_oe <= 1'b0;
		end else if (b.req && b.kind == BK_WR) begin
			data_bus_value <= b.narrow ? {8'h00, b.wdata[15:8]} : b.wdata;
			data_bus_oe <= 1'b1;
		end else if (next_byte && kind == BK_WR) begin
			data_bus_value <= {8'h00, wdata_q[7:0]};
		end else if (!(kind == BK_WR && st != E_IDLE && !last)) begin
			data_bus_value <= b.sd;
			data_bus_oe <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_enable <= 1'b0;
			mem_we_n <= 1'b1;
		end else if (b.req) begin
			mem_enable <= (b.kind == BK_RD) || (b.kind == BK_WR);
			mem_we_n <= (b.kind != BK_WR);
		end else if (last) begin
			mem_enable <= 1'b0;
			mem_we_n <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_bit_out <= 1'b0;
			serial_bit_strobe <= 1'b0;
		end else begin
			if (b.req && b.kind == BK_BOUT) begin
				serial_bit_out <= b.wbit;
			end
			serial_bit_strobe <= (st == E_T1) && (kind == BK_BOUT) && !b.req;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc_cnt <= 8'h00;
			stall_cnt <= 8'h00;
		end else if (b.req) begin
			cyc_cnt <= 8'h01;
			stall_cnt <= 8'h00;
		end else if (st != E_IDLE) begin
			cyc_cnt <= cyc_cnt + 8'h01;
			stall_cnt <= stall_cnt + {7'h00, stall};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_mem_len;
		last && is_mem |-> cyc_cnt == (narrow_q ? NARROW_BASE_CLKS : WIDE_BASE_CLKS) + stall_cnt;
	endproperty
	a_mem_len: assert property (p_mem_len) else $error("memory cycle length wrong");

	property p_bit_len;
		last && !is_mem |-> cyc_cnt == BIT_CLKS;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit cycle length wrong");

	property p_byte_order;
		(st == E_T1) && is_mem && narrow_q |-> byte_select_address_bit == byte_hi
			&& (kind != BK_WR || data_bus_value[7:0] == (byte_hi ? wdata_q[7:0] : wdata_q[15:8]));
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("byte transfer order wrong");

	property p_strobe;
		(st == E_T1) && (kind == BK_BOUT) && !b.req |=> serial_bit_strobe && (st == E_T2)
			&& serial_bit_out == $past(serial_bit_out) ##1 !serial_bit_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("bit strobe not in second clock");

	property p_hold_addr;
		(st == E_IDLE) && !b.req |=> $stable(address_bus_value) && !mem_enable && mem_we_n;
	endproperty
	a_hold_addr: assert property (p_hold_addr) else $error("address moved outside a cycle");

	property p_sd_shown;
		(st == E_IDLE) && !b.req |=> data_bus_value == $past(b.sd) && !data_bus_oe;
	endproperty
	a_sd_shown: assert property (p_sd_shown) else $error("data bus not showing latch");
endmodule : cmcs_bus_engine

/* logic/cmcs_sequencer.sv */
// Machine-cycle sequencer top: operand derivation and single cycles
`timescale 1ns/100ps
//
// Behaviour
// - Each machine cycle takes at least two clocks
// - ALU cycle leaves bus controls unchanged
// - Memory cycle drives bus controls throughout
// - Wide memory cycle lasts two plus waits
// - Narrow bus: two bytes, four plus 2W
// - High byte first at bit 0, then 1
// - Bit cycle two clocks, address first clock
// - Bit input sampled in second clock
// - Bit output set early, strobe second clock
// - Each step selects one fixed machine cycle
// - Derivation phase precedes execution phase
// - Derivation sequence depends on mode and byte indicator
// - Latch holds last write or ALU load, shown on bus
// - No-change cycles keep previous address
// - Byte indicator: one byte, zero word
// - Register mode: one read at register
// - Indirect: read, ALU, read operand
// - Byte autoinc: read, ALU, write +1, read
// - Word autoinc: read, two ALU, +2, read
// - Symbolic: two ALU, read PC+2, zero, read
// - Indexed: read, ALU, PC+2, ALU, indexed read
module cmcs_sequencer
	import cmcs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        deriv_start,
	input  wire logic [2:0]  deriv_mode,
	input  wire logic        deriv_byte,
	input  wire logic [15:0] deriv_ws_addr,
	input  wire logic [15:0] deriv_pc,
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_kind,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [15:0] cmd_data,
	input  wire logic        cmd_bit,
	output logic             cmd_ready,
	output logic             busy,
	output logic             done,
	output logic [15:0]      operand,
	output logic             bit_result,
	input  wire logic        narrow_bus,
	input  wire logic        wait_req,
	input  wire logic [15:0] data_in,
	output logic [15:0]      address_bus_value,
	output logic [15:0]      data_bus_value,
	output logic             data_bus_oe,
	output logic             mem_enable,
	output logic             mem_we_n,
	output logic             byte_select_address_bit,
	input  wire logic        serial_bit_in,
	output logic             serial_bit_out,
	output logic             serial_bit_strobe
);
	cmcs_bus_if  b ();
	cmcs_state_t state;
	logic [2:0]  sync1;
	logic [2:0]  sync2;
	logic [2:0]  idx;
	logic [2:0]  mc_count;
	cmcs_mode_t  mode;
	logic        byte_q;
	logic        single;
	logic [15:0] ws_addr;
	logic [15:0] pc;
	logic [15:0] ext_addr;
	logic [15:0] ext_data;
	logic        ext_bit;
	logic [15:0] wsc;
	logic [15:0] symb;
	logic [15:0] source_data_latch;
	logic        advance;
	cmcs_step_t  nstep;
	cmcs_step_t  cur;
	logic [15:0] c_ws;
	logic [15:0] c_pc;
	logic [15:0] c_ea;
	logic [15:0] c_ed;

	// ****************************************
	// Step tables
	// ****************************************
	function automatic cmcs_step_t step_of(cmcs_mode_t m, logic bsel, logic [2:0] i);
		cmcs_step_t s;
		s = '{OP_END, A_WSA, D_KEEP};
		case (m)
			M_REG: if (i == 3'h0) s = '{OP_RD, A_WSA, D_KEEP};
			M_IND: case (i)
				3'h0: s = '{OP_RD, A_WSA, D_KEEP};
				3'h1: s = '{OP_ALU, A_WSA, D_KEEP};
				3'h2: s = '{OP_RD, A_WSC, D_KEEP};
				default: s = '{OP_END, A_WSA, D_KEEP};
			endcase
			M_AUTO: case (i)
				3'h0: s = '{OP_RD, A_WSA, D_KEEP};
				3'h1: s = '{OP_ALU, A_WSA, D_KEEP};
				3'h2: s = bsel ? cmcs_step_t'{OP_WR, A_WSA, D_INC} : cmcs_step_t'{OP_ALU, A_WSA, D_KEEP};
				3'h3: s = bsel ? cmcs_step_t'{OP_RD, A_WSC, D_KEEP} : cmcs_step_t'{OP_WR, A_WSA, D_INC};
				3'h4: s = bsel ? cmcs_step_t'{OP_END, A_WSA, D_KEEP} : cmcs_step_t'{OP_RD, A_WSC, D_KEEP};
				default: s = '{OP_END, A_WSA, D_KEEP};
			endcase
			M_SYM: case (i)
				3'h0, 3'h1: s = '{OP_ALU, A_WSA, D_KEEP};
				3'h2: s = '{OP_RD, A_PC2, D_KEEP};
				3'h3: s = '{OP_ALU, A_WSA, D_ZERO};
				3'h4: s = '{OP_RD, A_SYM, D_KEEP};
				default: s = '{OP_END, A_WSA, D_KEEP};
			endcase
			M_IDX: case (i)
				3'h0: s = '{OP_RD, A_WSA, D_KEEP};
				3'h1: s = '{OP_ALU, A_WSA, D_KEEP};
				3'h2: s = '{OP_RD, A_PC2, D_KEEP};
				3'h3: s = '{OP_ALU, A_WSA, D_WSC};
				3'h4: s = '{OP_RD, A_SYMX, D_KEEP};
				default: s = '{OP_END, A_WSA, D_KEEP};
			endcase
			default: s = '{OP_END, A_WSA, D_KEEP};
		endcase
		return s;
	endfunction : step_of

	function automatic cmcs_step_t cmd_step(logic [2:0] k);
		cmcs_step_t s;
		case (k)
			C_ALU_KEEP: s = '{OP_ALU, A_EXT, D_KEEP};
			C_ALU_LOAD: s = '{OP_ALU, A_EXT, D_EXT};
			C_RD: s = '{OP_RD, A_EXT, D_KEEP};
			C_WR: s = '{OP_WR, A_EXT, D_EXT};
			C_BIN: s = '{OP_BIN, A_EXT, D_KEEP};
			C_BOUT: s = '{OP_BOUT, A_EXT, D_KEEP};
			default: s = '{OP_END, A_EXT, D_KEEP};
		endcase
		return s;
	endfunction : cmd_step

	function automatic logic [2:0] len_of(cmcs_mode_t m, logic bsel);
		case (m)
			M_REG: return LEN_REG;
			M_IND: return LEN_IND;
			M_AUTO: return bsel ? LEN_AUTO_B : LEN_LONG;
			default: return LEN_LONG;
		endcase
	endfunction : len_of

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {narrow_bus, wait_req, serial_bit_in};
			sync2 <= sync1;
		end
	end

	// ****************************************
	// Next step selection
	// ****************************************
	always_comb begin
		c_ws = (state == S_IDLE) ? deriv_ws_addr : ws_addr;
		c_pc = (state == S_IDLE) ? deriv_pc : pc;
		c_ea = (state == S_IDLE) ? cmd_addr : ext_addr;
		c_ed = (state == S_IDLE) ? cmd_data : ext_data;
		advance = ((state == S_IDLE) && (deriv_start || cmd_valid)) || (state == S_ALU1)
			|| ((state == S_BUS) && b.done);
		if (state == S_IDLE) begin
			if (deriv_start) begin
				nstep = step_of(cmcs_mode_t'(deriv_mode), deriv_byte, 3'h0);
			end else begin
				nstep = cmd_step(cmd_kind);
			end
		end else if (single) begin
			nstep = '{OP_END, A_EXT, D_KEEP};
		end else begin
			nstep = step_of(mode, byte_q, idx + 3'h1);
		end
		cur = advance ? nstep : cmcs_step_t'{OP_END, A_EXT, D_KEEP};
	end

	// ****************************************
	// Request to the bus engine
	// ****************************************
	always_comb begin
		b.req = (cur.op == OP_RD) || (cur.op == OP_WR) || (cur.op == OP_BIN) || (cur.op == OP_BOUT);
		case (cur.op)
			OP_WR: b.kind = BK_WR;
			OP_BIN: b.kind = BK_BIN;
			OP_BOUT: b.kind = BK_BOUT;
			default: b.kind = BK_RD;
		endcase
		case (cur.asrc)
			A_WSC: b.addr = wsc;
			A_PC2: b.addr = c_pc + PC_STEP;
			A_SYM: b.addr = symb;
			A_SYMX: b.addr = symb + wsc;
			A_EXT: b.addr = c_ea;
			default: b.addr = c_ws;
		endcase
		case (cur.dsrc)
			D_INC: b.wdata = wsc + (byte_q ? INC_BYTE : INC_WORD);
			D_EXT: b.wdata = c_ed;
			default: b.wdata = source_data_latch;
		endcase
		b.wbit = (state == S_IDLE) ? cmd_bit : ext_bit;
		b.narrow = sync2[2];
		b.sd = source_data_latch;
	end

	// ****************************************
	// Machine cycle state
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_ALU0: state <= S_ALU1;
				default: if (advance) begin
					case (cur.op)
						OP_END: state <= S_IDLE;
						OP_ALU: state <= S_ALU0;
						default: state <= S_BUS;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx <= 3'h0;
			mc_count <= 3'h0;
			mode <= M_REG;
			byte_q <= 1'b0;
			single <= 1'b0;
			ws_addr <= ADDR_RESET;
			pc <= ADDR_RESET;
			ext_addr <= ADDR_RESET;
			ext_data <= ZERO_WORD;
			ext_bit <= 1'b0;
		end else if (state == S_IDLE && advance) begin
			idx <= 3'h0;
			mc_count <= 3'h1;
			mode <= cmcs_mode_t'(deriv_mode);
			byte_q <= deriv_byte;
			single <= !deriv_start;
			ws_addr <= deriv_ws_addr;
			pc <= deriv_pc;
			ext_addr <= cmd_addr;
			ext_data <= cmd_data;
			ext_bit <= cmd_bit;
		end else if (advance && cur.op != OP_END) begin
			idx <= idx + 3'h1;
			mc_count <= mc_count + 3'h1;
		end
	end

	// ****************************************
	// Source data latch and read results
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			source_data_latch <= SD_RESET;
		end else if (cur.op == OP_WR) begin
			source_data_latch <= b.wdata;
		end else if (cur.op == OP_ALU) begin
			case (cur.dsrc)
				D_ZERO: source_data_latch <= ZERO_WORD;
				D_WSC: source_data_latch <= wsc;
				D_EXT: source_data_latch <= c_ed;
				default: source_data_latch <= source_data_latch;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wsc <= ZERO_WORD;
			symb <= ZERO_WORD;
			operand <= ZERO_WORD;
		end else if (state == S_BUS && b.done) begin
			if (b.kind == BK_RD || cur.op == OP_END || cur.op != OP_WR) begin
				operand <= b.rdata;
			end
			if (!single && idx == 3'h0) begin
				wsc <= b.rdata;
			end
			if (!single && idx == 3'h2 && (mode == M_SYM || mode == M_IDX)) begin
				symb <= b.rdata;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
		end else begin
			done <= advance && (state != S_IDLE) && (cur.op == OP_END);
		end
	end

	assign cmd_ready = (state == S_IDLE) && !deriv_start;
	assign busy = (state != S_IDLE);
	assign bit_result = b.rbit;

	// ****************************************
	// Bus engine
	// ****************************************
	cmcs_bus_engine u_engine (
		.clk                     (clk),
		.rst                     (rst),
		.b                       (b),
		.wait_sync               (sync2[1]),
		.serial_in_sync          (sync2[0]),
		.din                     (data_in),
		.address_bus_value       (address_bus_value),
		.data_bus_value          (data_bus_value),
		.data_bus_oe             (data_bus_oe),
		.mem_enable              (mem_enable),
		.mem_we_n                (mem_we_n),
		.byte_select_address_bit (byte_select_address_bit),
		.serial_bit_out          (serial_bit_out),
		.serial_bit_strobe       (serial_bit_strobe)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_alu_two;
		state == S_ALU0 |=> state == S_ALU1 ##1 state != S_ALU1;
	endproperty
	a_alu_two: assert property (p_alu_two) else $error("ALU cycle not two clocks");

	property p_alu_quiet;
		state == S_ALU0 |=> $stable(address_bus_value) && $stable(mem_enable) && $stable(mem_we_n)
			&& $stable(serial_bit_out) && !serial_bit_strobe;
	endproperty
	a_alu_quiet: assert property (p_alu_quiet) else $error("ALU cycle moved bus controls");

	property p_seq_len;
		done && !single |-> mc_count == len_of(mode, byte_q);
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("derivation length wrong");

	property p_inc_write;
		b.req && b.kind == BK_WR && !single && state != S_IDLE |-> b.wdata == wsc + (byte_q ? INC_BYTE : INC_WORD)
			&& b.addr == ws_addr;
	endproperty
	a_inc_write: assert property (p_inc_write) else $error("autoincrement write wrong");

	property p_sym_zero;
		state == S_ALU0 && mode == M_SYM && idx == 3'h3 && !single |-> source_data_latch == ZERO_WORD;
	endproperty
	a_sym_zero: assert property (p_sym_zero) else $error("symbolic zero not loaded");

	property p_pc_read;
		b.req && !single && idx == 3'h1 && state == S_ALU1 && (mode == M_IDX || mode == M_SYM)
			|-> b.addr == pc + PC_STEP;
	endproperty
	a_pc_read: assert property (p_pc_read) else $error("symbolic address fetch wrong");
endmodule : cmcs_sequencer

/* tb/cmcs_mem_model.sv */
// Memory and bit-serial device model on the far side of the sequencer
`timescale 1ns/100ps
module cmcs_mem_model (
	input  wire logic        clk,
	input  wire logic        narrow,
	input  wire logic        waits,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        oe,
	input  wire logic        en,
	input  wire logic        we_n,
	input  wire logic        bout,
	input  wire logic        strobe,
	output logic [15:0]      rdata,
	output logic             wreq,
	output logic             bin
);
	logic [7:0]  mem [0:255];
	logic [15:0] bit_pat;
	logic [15:0] out_bits;
	logic [15:0] last;
	logic [3:0]  en_cnt;
	int          strobes;
	initial begin
		bit_pat = 16'h0020;
		out_bits = 16'h0000;
		last = 16'h0000;
		en_cnt = 4'h0;
		strobes = 0;
	end
	// Read data while selected, scrambled once released
	always_comb begin
		if (en && narrow) rdata = {8'h00, mem[addr[7:0]]};
		else if (en) rdata = {mem[addr[7:0]], mem[addr[7:0] | 8'h01]};
		else rdata = ~last;
	end
	// Slow memory keeps its wait request up until two clocks of a transfer have passed
	assign wreq = waits && !(en && (en_cnt >= 4'h2));
	// Addressed bit held valid through the bit cycle
	assign bin = bit_pat[addr[3:0]];
	always @(posedge clk) begin
		last <= rdata;
		en_cnt <= en ? en_cnt + 4'h1 : 4'h0;
		if (en && !we_n && oe && narrow) mem[addr[7:0]] <= wdata[7:0];
		if (en && !we_n && oe && !narrow) begin
			mem[addr[7:0]] <= wdata[15:8];
			mem[addr[7:0] | 8'h01] <= wdata[7:0];
		end
		if (strobe) begin
			out_bits[addr[3:0]] <= bout;
			strobes <= strobes + 1;
		end
	end
endmodule : cmcs_mem_model

/* tb/testbench.sv */
// Self-checking bench of the machine-cycle sequencer
`timescale 1ns/100ps
module testbench;
	import cmcs_pkg::*;
	logic clk = 0, rst = 1, d_start = 0, d_byte = 0, c_valid = 0, c_bit = 0, narrow = 0, waits = 0;
	logic [2:0] d_mode = 3'h0, c_kind = 3'h0;
	logic [15:0] c_addr = 16'h0000, c_data = 16'h0000, din, ab, dbv, operand;
	logic wreq, sin, sout, strobe, done, bit_result, oe, en, we_n, busy, ready, bsel;
	int fail_count = 0, checked = 0, lat;
	always #12.5 clk = ~clk;
	cmcs_sequencer DUT (.clk(clk), .rst(rst), .deriv_start(d_start), .deriv_mode(d_mode), .deriv_byte(d_byte),
		.deriv_ws_addr(16'h0010), .deriv_pc(16'h0020), .cmd_valid(c_valid), .cmd_kind(c_kind),
		.cmd_addr(c_addr), .cmd_data(c_data), .cmd_bit(c_bit), .cmd_ready(ready), .busy(busy), .done(done),
		.operand(operand), .bit_result(bit_result), .narrow_bus(narrow), .wait_req(wreq), .data_in(din),
		.address_bus_value(ab), .data_bus_value(dbv), .data_bus_oe(oe), .mem_enable(en), .mem_we_n(we_n),
		.byte_select_address_bit(bsel), .serial_bit_in(sin), .serial_bit_out(sout), .serial_bit_strobe(strobe));
	cmcs_mem_model u_mem (.clk(clk), .narrow(narrow), .waits(waits), .addr(ab), .wdata(dbv), .oe(oe),
		.en(en), .we_n(we_n), .bout(sout), .strobe(strobe), .rdata(din), .wreq(wreq), .bin(sin));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic issue(input logic d, input logic [2:0] k, input logic [15:0] a, input logic [15:0] v);
		@(negedge clk);
		d_start = d;
		c_valid = !d;
		d_mode = k;
		c_kind = k;
		c_addr = a;
		c_data = v;
		c_bit = v[0];
		@(negedge clk);
		d_start = 0;
		c_valid = 0;
		lat = 1;
		chk({13'h0, busy, ready, done}, 16'h0004);
		while (done !== 1'b1 && lat < 200) begin
			@(negedge clk);
			lat++;
		end
		chk({13'h0, busy, ready, done}, 16'h0003);
	endtask : issue
	task automatic put(input logic [7:0] a, input logic [15:0] w);
		u_mem.mem[a] = w[15:8];
		u_mem.mem[a + 8'h01] = w[7:0];
	endtask : put
	task automatic t_modes;
		issue(1, 3'h0, 0, 0);
		chk(operand, 16'h0040);
		chk(16'(lat), 16'h0003);
		issue(1, 3'h1, 0, 0);
		chk(operand, 16'hBEEF);
		chk(16'(lat), 16'h0007);
		issue(1, 3'h3, 0, 0);
		chk(operand, 16'h1234);
		chk(16'(lat), 16'h000B);
		issue(1, 3'h4, 0, 0);
		chk(operand, 16'hCAFE);
		chk(16'(lat), 16'h000B);
	endtask : t_modes
	task automatic t_autoinc;
		d_byte = 0;
		issue(1, 3'h2, 0, 0);
		chk(operand, 16'hBEEF);
		chk(16'(lat), 16'h000B);
		chk({u_mem.mem[16], u_mem.mem[17]}, 16'h0042);
		d_byte = 1;
		issue(1, 3'h2, 0, 0);
		chk(operand, 16'h5A5A);
		chk(16'(lat), 16'h0009);
		chk({u_mem.mem[16], u_mem.mem[17]}, 16'h0043);
	endtask : t_autoinc
	task automatic t_latch;
		issue(0, 3'h1, 0, 16'h7777);
		@(negedge clk);
		chk(dbv, 16'h7777);
		issue(0, 3'h2, 16'h0050, 0);
		issue(0, 3'h0, 0, 0);
		chk(ab, 16'h0050);
		chk({15'h0, en}, 16'h0000);
		chk(16'(lat), 16'h0003);
	endtask : t_latch
	task automatic t_narrow;
		@(negedge clk);
		narrow = 1;
		repeat (4) @(negedge clk);
		issue(0, 3'h2, 16'h0050, 0);
		chk(operand, 16'h1234);
		chk({15'h0, bsel}, 16'h0001);
		chk(16'(lat), 16'h0005);
		issue(0, 3'h3, 16'h0060, 16'hA55A);
		chk({u_mem.mem[96], u_mem.mem[97]}, 16'hA55A);
		chk(16'(lat), 16'h0005);
		narrow = 0;
		repeat (4) @(negedge clk);
	endtask : t_narrow
	task automatic t_bits;
		issue(0, 3'h5, 16'h0003, 16'h0001);
		chk(u_mem.out_bits, 16'h0008);
		chk(16'(u_mem.strobes), 16'h0001);
		chk(16'(lat), 16'h0003);
		issue(0, 3'h4, 16'h0005, 0);
		@(negedge clk);
		chk({15'h0, bit_result}, 16'h0001);
		issue(0, 3'h4, 16'h0004, 0);
		@(negedge clk);
		chk({15'h0, bit_result}, 16'h0000);
	endtask : t_bits
	task automatic t_waits;
		waits = 1;
		issue(0, 3'h2, 16'h0050, 0);
		chk(operand, 16'h1234);
		chk(16'(lat), 16'h0006);
		waits = 0;
		issue(0, 3'h3, 16'h0070, 16'h0F0F);
		chk({u_mem.mem[112], u_mem.mem[113]}, 16'h0F0F);
	endtask : t_waits
	initial begin
		put(8'h10, 16'h0040);
		put(8'h40, 16'hBEEF);
		put(8'h42, 16'h5A5A);
		put(8'h22, 16'h0050);
		put(8'h50, 16'h1234);
		put(8'h90, 16'hCAFE);
		repeat (16) @(negedge clk);
		rst = 0;
		t_modes();
		t_autoinc();
		t_latch();
		t_narrow();
		t_bits();
		t_waits();
		stop_test();
	end
	initial begin
		#(25 * 5000);
		fail_count++;
		stop_test();
	end
endmodule : testbench
